// [hw/rfe_engine.sv]
// Reflex block engine with output fallback and heartbeat supervision
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module rfe_engine
  import rfe_pkg::*;
#(
  parameter int NB = 10,
  parameter int NCH = 8,
  parameter int NDI = 8,
  parameter int NAI = 2,
  parameter int MS_CYCLES = MS_CYC,
  parameter logic [15:0] HB_PER = HB_PER_MS
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // Island inputs
  input wire logic [NDI-1:0] dig_in,
  input wire logic [NAI-1:0][15:0] ana_in,
  input wire logic [NDI-1:0] dig_fail_in,
  input wire logic [NAI-1:0] ana_fail_in,
  // Supervision
  input wire logic bus_lost_in,
  input wire logic mod_hb_miss_in,
  input wire logic mand_fail_in,
  input wire logic auto_cfg_in,
  // Island outputs
  output logic [NCH-1:0][15:0] chan_out,
  output logic [NCH-1:0] chan_fb_out,
  output logic hb_tx_out
);
  localparam int PW = NDI + NAI * 16 + NDI + NAI + 4;
  localparam int MW = $clog2(MS_CYCLES);
  localparam int NM = NCH / 2;

  typedef struct packed {
    logic [PW-1:0] s1;
    logic [PW-1:0] s2;
    logic [NDI-1:0] dg;
    logic [NDI-1:0][3:0] dlk;
    logic [NAI-1:0][15:0] aw;
    logic [NAI-1:0][3:0] alk;
    logic [MW-1:0] pre;
    logic tick;
    logic [15:0] hbc;
    logic [15:0] wd;
    logic hb;
    logic run;
    logic [15:0] sup;
    logic [NB-1:0][15:0] bcfg;
    logic [NB-1:0][15:0] bctl;
    logic [NB-1:0][15:0] bpre;
    logic [NB-1:0][15:0] bdel;
    logic [NB-1:0][15:0] bufw;
    logic [NB-1:0] bufb;
    logic [NCH-1:0][15:0] cdat;
    logic [NCH-1:0][1:0] ccfg;
    logic [NCH-1:0][15:0] cfbv;
    logic [NCH-1:0][15:0] cout;
    logic [NCH-1:0] cfb;
    logic [15:0] rdat;
  } rfe_st_s;

  rfe_st_s st_ff;
  rfe_st_s nxt_st;

  // Synchronised pin fields
  logic [NDI-1:0] sd;
  logic [NAI-1:0][15:0] sa;
  logic [NDI-1:0] sdf;
  logic [NAI-1:0] saf;
  logic sbl;
  logic shm;
  logic smf;
  logic sac;

  assign sd = st_ff.s2[NDI-1:0];
  assign sa = st_ff.s2[NDI +: NAI*16];
  assign sdf = st_ff.s2[NDI + NAI*16 +: NDI];
  assign saf = st_ff.s2[2*NDI + NAI*16 +: NAI];
  assign sbl = st_ff.s2[PW-4];
  assign shm = st_ff.s2[PW-3];
  assign smf = st_ff.s2[PW-2];
  assign sac = st_ff.s2[PW-1];

  // Block results and nesting
  logic [NB-1:0] rbit_w;
  logic [NB-1:0][15:0] rword_w;
  logic [NB-1:0][15:0] res_w;
  logic [NB:0] nst;

  always_comb begin
    logic prev;
    prev = 1'b1;
    nst = '0;
    // Only a block whose predecessor has C_NEST clear may nest; block 0 never nests
    for (int b = 0; b < NB; b++) begin
      nst[b] = st_ff.bctl[b][C_NEST] & ~prev;
      prev = st_ff.bctl[b][C_NEST];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : gen_blk
      localparam int GP = (g > 0) ? g - 1 : 0;
      rfe_blk_if bif ();
      assign bif.kind = rfe_kind_e'(st_ff.bcfg[g][F_TYP +: 3]);
      assign bif.en = st_ff.bcfg[g][F_ENA] |
        sd_sel(st_ff.dg, st_ff.bcfg[g][F_SE +: SRCW]);
      assign bif.a = nst[g] ? st_ff.bufb[GP] :
        sd_sel(st_ff.dg, st_ff.bcfg[g][F_SA +: SRCW]);
      assign bif.b = sd_sel(st_ff.dg, st_ff.bcfg[g][F_SB +: SRCW]);
      assign bif.w = nst[g] ? st_ff.bufw[GP] :
        st_ff.aw[st_ff.bctl[g][C_ANA]];
      assign bif.down = st_ff.bctl[g][C_DOWN];
      assign bif.tbase = st_ff.bctl[g][C_TB +: 2];
      assign bif.pre = st_ff.bpre[g];
      assign bif.dlt = st_ff.bdel[g];
      assign rbit_w[g] = bif.rbit;
      assign rword_w[g] = bif.rword;
      // Word-typed blocks pass their word, the rest a Boolean
      assign res_w[g] = (bif.kind == RFE_CNT || bif.kind == RFE_ALAT) ?
        bif.rword : {15'h0000, bif.rbit};
      rfe_block u_blk (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .ms_tick_in(st_ff.tick),
        .bi(bif.blk)
      );
    end
  endgenerate

  function automatic logic sd_sel(input logic [NDI-1:0] v,
                                  input logic [SRCW-1:0] i);
    sd_sel = v[i];
  endfunction

  // Fallback and register logic
  logic any_fb;
  logic stop;
  logic wd_exp;
  logic [NB-1:0] mok;
  logic [NB-1:0] bf;
  logic [NCH-1:0] refl;
  logic [NCH-1:0] sf;
  logic [NCH-1:0][15:0] lv;
  logic [7:0] off;
  logic [5:0] ix;
  logic [1:0] ks;

  always_comb begin
    logic [NM-1:0][1:0] mcnt;
    logic [CHW-2:0] m;
    logic hst;
    logic pf;
    logic both;
    logic fb;
    mcnt = '0;
    m = '0;
    hst = 1'b0;
    pf = 1'b0;
    both = 1'b0;
    fb = 1'b0;
    nxt_st = st_ff;
    off = '0;
    ix = '0;
    ks = '0;

    nxt_st.s1 = {auto_cfg_in, mand_fail_in, mod_hb_miss_in, bus_lost_in,
      ana_fail_in, dig_fail_in, ana_in, dig_in};
    nxt_st.s2 = st_ff.s1;

    // Millisecond time base
    nxt_st.tick = 1'b0;
    if (st_ff.pre == MW'(MS_CYCLES - 1)) begin
      nxt_st.pre = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.pre = st_ff.pre + 1'b1;
    end

    // Change-of-state acceptance with lockout; a change during lockout
    // is taken once the lockout ends if it still stands
    for (int i = 0; i < NDI; i++) begin
      if (st_ff.dlk[i] != 4'h0) begin
        if (st_ff.tick) begin
          nxt_st.dlk[i] = st_ff.dlk[i] - 4'h1;
        end
      end else if (sd[i] != st_ff.dg[i]) begin
        nxt_st.dg[i] = sd[i];
        nxt_st.dlk[i] = DEB_MS;
      end
    end
    for (int i = 0; i < NAI; i++) begin
      if (st_ff.alk[i] != 4'h0) begin
        if (st_ff.tick) begin
          nxt_st.alk[i] = st_ff.alk[i] - 4'h1;
        end
      end else if (sa[i] != st_ff.aw[i]) begin
        nxt_st.aw[i] = sa[i];
        nxt_st.alk[i] = DEB_MS;
      end
    end

    // Fallback causes
    stop = ~st_ff.run;
    any_fb = sbl | shm | stop | smf;

    // Heartbeat send and supervision
    nxt_st.hb = 1'b0;
    if (st_ff.tick) begin
      if (st_ff.hbc >= HB_PER - 16'h0001) begin
        nxt_st.hbc = '0;
        nxt_st.hb = ~any_fb;
      end else begin
        nxt_st.hbc = st_ff.hbc + 16'h0001;
      end
      if (st_ff.wd != 16'hFFFF) begin
        nxt_st.wd = st_ff.wd + 16'h0001;
      end
    end
    if (st_ff.hb) begin
      nxt_st.wd = '0;
    end
    wd_exp = st_ff.wd >= st_ff.sup;

    // Module hosting limit and source failure per block
    for (int b = 0; b < NB; b++) begin
      m = st_ff.bctl[b][C_CH + 1 +: CHW - 1];
      hst = st_ff.bctl[b][C_MAP] | nst[b + 1];
      mok[b] = st_ff.bctl[b][C_MAP] && (mcnt[m] < 2'h2);
      if (hst && mcnt[m] < 2'h2) begin
        mcnt[m] = mcnt[m] + 2'h1;
      end
      bf[b] = (~st_ff.bcfg[b][F_ENA] & sdf[st_ff.bcfg[b][F_SE +: SRCW]]) |
        sdf[st_ff.bcfg[b][F_SA +: SRCW]] |
        sdf[st_ff.bcfg[b][F_SB +: SRCW]] |
        (~nst[b] & saf[st_ff.bctl[b][C_ANA]]) | (nst[b] & pf);
      pf = bf[b];
      if (!st_ff.bctl[b][C_MAP]) begin
        nxt_st.bufw[b] = rword_w[b];
        nxt_st.bufb[b] = rbit_w[b];
      end
    end

    // Channel sources
    for (int c = 0; c < NCH; c++) begin
      refl[c] = 1'b0;
      sf[c] = 1'b0;
      lv[c] = st_ff.cdat[c];
      for (int b = 0; b < NB; b++) begin
        if (mok[b] && st_ff.bctl[b][C_CH +: CHW] == CHW'(c)) begin
          refl[c] = 1'b1;
          lv[c] = res_w[b];
          sf[c] = bf[b];
        end
      end
    end

    // Channel fallback and value
    for (int c = 0; c < NCH; c++) begin
      both = refl[(c/2)*2] & refl[(c/2)*2 + 1] &
        ~st_ff.ccfg[(c/2)*2][K_ANA] & ~st_ff.ccfg[(c/2)*2 + 1][K_ANA];
      if (refl[c]) begin
        // Reflex channels ride through a lost heartbeat
        fb = stop | smf | sf[c] | (sbl & ~both);
      end else begin
        fb = any_fb | wd_exp;
      end
      nxt_st.cfb[c] = fb;
      if (!fb) begin
        nxt_st.cout[c] = lv[c];
      end else if (sac) begin
        nxt_st.cout[c] = '0;
      end else if (st_ff.ccfg[c][K_HOLD]) begin
        nxt_st.cout[c] = st_ff.cout[c];
      end else if (st_ff.ccfg[c][K_ANA]) begin
        nxt_st.cout[c] = st_ff.cfbv[c];
      end else begin
        nxt_st.cout[c] = {15'h0000, st_ff.cfbv[c][0]};
      end
    end

    // Register writes
    if (reg_wr_in) begin
      if (reg_addr_in == A_CTRL) begin
        nxt_st.run = reg_wdata_in[0];
      end else if (reg_addr_in == A_SUP) begin
        nxt_st.sup = reg_wdata_in;
      end else if (reg_addr_in >= A_BLK && reg_addr_in < A_RES) begin
        off = reg_addr_in - A_BLK;
        ix = off[7:2];
        ks = off[1:0];
        if (int'(ix) < NB) begin
          unique case (ks)
            BK_CFG: nxt_st.bcfg[ix] = reg_wdata_in;
            BK_CTL: nxt_st.bctl[ix] = reg_wdata_in;
            BK_PRE: nxt_st.bpre[ix] = reg_wdata_in;
            BK_DEL: nxt_st.bdel[ix] = reg_wdata_in;
          endcase
        end
      end else if (reg_addr_in >= A_CH) begin
        off = reg_addr_in - A_CH;
        ix = off[7:2];
        ks = off[1:0];
        if (int'(ix) < NCH) begin
          unique case (ks)
            CK_DAT: nxt_st.cdat[ix] = reg_wdata_in;
            CK_CFG: nxt_st.ccfg[ix] = reg_wdata_in[1:0];
            CK_FBV: nxt_st.cfbv[ix] = reg_wdata_in;
            CK_OUT: ;
          endcase
        end
      end
    end

    // Register reads; data stands only in the following cycle
    nxt_st.rdat = '0;
    if (reg_rd_in) begin
      if (reg_addr_in == A_CTRL) begin
        nxt_st.rdat = {15'h0000, st_ff.run};
      end else if (reg_addr_in == A_SUP) begin
        nxt_st.rdat = st_ff.sup;
      end else if (reg_addr_in == A_STAT) begin
        nxt_st.rdat = {10'h000, sac, wd_exp, smf, stop, shm, sbl};
      end else if (reg_addr_in == A_CHFB) begin
        nxt_st.rdat = 16'(st_ff.cfb);
      end else if (reg_addr_in >= A_BLK && reg_addr_in < A_RES) begin
        off = reg_addr_in - A_BLK;
        ix = off[7:2];
        ks = off[1:0];
        if (int'(ix) < NB) begin
          unique case (ks)
            BK_CFG: nxt_st.rdat = st_ff.bcfg[ix];
            BK_CTL: nxt_st.rdat = st_ff.bctl[ix];
            BK_PRE: nxt_st.rdat = st_ff.bpre[ix];
            BK_DEL: nxt_st.rdat = st_ff.bdel[ix];
          endcase
        end
      end else if (reg_addr_in >= A_RES && reg_addr_in < A_CH) begin
        off = reg_addr_in - A_RES;
        if (int'(off) < NB) begin
          nxt_st.rdat = res_w[off[5:0]];
        end
      end else if (reg_addr_in >= A_CH) begin
        off = reg_addr_in - A_CH;
        ix = off[7:2];
        ks = off[1:0];
        if (int'(ix) < NCH) begin
          unique case (ks)
            CK_DAT: nxt_st.rdat = st_ff.cdat[ix];
            CK_CFG: nxt_st.rdat = {14'h0000, st_ff.ccfg[ix]};
            CK_FBV: nxt_st.rdat = st_ff.cfbv[ix];
            CK_OUT: nxt_st.rdat = st_ff.cout[ix];
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
      st_ff.run <= RUN_RST;
      st_ff.sup <= SUP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_out = st_ff.rdat;
  assign chan_out = st_ff.cout;
  assign chan_fb_out = st_ff.cfb;
  assign hb_tx_out = st_ff.hb;
endmodule // rfe_engine
`default_nettype wire

// [hw/rfe_pkg.sv]
// Shared constants and types of the reflex and fallback engine
package rfe_pkg;
  // Timing
  localparam int CLK_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] DEB_MS = 4'hA;
  localparam logic [9:0] TB_1MS = 10'h001;
  localparam logic [9:0] TB_10MS = 10'h00A;
  localparam logic [9:0] TB_100MS = 10'h064;
  localparam logic [9:0] TB_1000MS = 10'h3E8;
  localparam logic [15:0] HB_PER_MS = 16'h0032;
  // Register map (16-bit registers, word index)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SUP = 8'h01;
  localparam logic [7:0] A_STAT = 8'h02;
  localparam logic [7:0] A_CHFB = 8'h03;
  localparam logic [7:0] A_BLK = 8'h10;
  localparam logic [7:0] A_RES = 8'h38;
  localparam logic [7:0] A_CH = 8'h50;
  localparam logic [1:0] BK_CFG = 2'h0;
  localparam logic [1:0] BK_CTL = 2'h1;
  localparam logic [1:0] BK_PRE = 2'h2;
  localparam logic [1:0] BK_DEL = 2'h3;
  localparam logic [1:0] CK_DAT = 2'h0;
  localparam logic [1:0] CK_CFG = 2'h1;
  localparam logic [1:0] CK_FBV = 2'h2;
  localparam logic [1:0] CK_OUT = 2'h3;
  // Reset values
  localparam logic [15:0] SUP_RST = 16'h0064;
  localparam logic RUN_RST = 1'b0;
  // Block CFG fields
  localparam int F_TYP = 0;
  localparam int F_ENA = 3;
  localparam int F_SE = 4;
  localparam int F_SA = 8;
  localparam int F_SB = 12;
  localparam int SRCW = 3;
  // Block CTL fields
  localparam int C_NEST = 0;
  localparam int C_ANA = 1;
  localparam int C_DOWN = 2;
  localparam int C_TB = 3;
  localparam int C_MAP = 5;
  localparam int C_CH = 6;
  localparam int CHW = 3;
  // Channel CFG fields
  localparam int K_HOLD = 0;
  localparam int K_ANA = 1;
  typedef enum logic [2:0] {
    RFE_AND, RFE_XOR, RFE_CMP, RFE_CNT, RFE_TMR, RFE_DLAT, RFE_ALAT
  } rfe_kind_e;
endpackage

// [hw/rfe_blk_if.sv]
// Signals between the engine and one reflex block evaluator
`timescale 1ns/1ps
`default_nettype none
interface rfe_blk_if;
  import rfe_pkg::*;
  rfe_kind_e kind;
  logic en;
  logic a;
  logic b;
  logic down;
  logic [1:0] tbase;
  logic [15:0] w;
  logic [15:0] pre;
  logic [15:0] dlt;
  logic rbit;
  logic [15:0] rword;
  modport blk (input kind, en, a, b, down, tbase, w, pre, dlt,
    output rbit, rword);
  modport host (output kind, en, a, b, down, tbase, w, pre, dlt,
    input rbit, rword);
endinterface
`default_nettype wire

// [hw/rfe_block.sv]
// One reflex function block: logic, compare, counter, timer, latches
`timescale 1ns/1ps
`default_nettype none
module rfe_block
  import rfe_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Millisecond time base
  input wire logic ms_tick_in,
  // Block signals
  rfe_blk_if.blk bi
);
  typedef struct packed {
    logic [15:0] acc;
    logic [9:0] sub;
    logic run;
    logic pa;
    logic rbit;
  } rfe_blk_s;

  rfe_blk_s st_ff;
  rfe_blk_s nxt_st;
  logic [9:0] tb;

  always_comb begin
    nxt_st = st_ff;
    unique case (bi.tbase)
      2'h0: tb = TB_1MS;
      2'h1: tb = TB_10MS;
      2'h2: tb = TB_100MS;
      2'h3: tb = TB_1000MS;
    endcase
    nxt_st.pa = bi.a;
    // Timer reset acts even while the block is disabled
    if (bi.kind == RFE_TMR && bi.b) begin
      nxt_st.acc = '0;
      nxt_st.sub = '0;
      nxt_st.run = 1'b0;
      nxt_st.rbit = 1'b0;
    end else if (bi.en) begin
      unique case (bi.kind)
        RFE_AND: nxt_st.rbit = bi.a & bi.b;
        RFE_XOR: nxt_st.rbit = bi.a ^ bi.b;
        RFE_CMP: begin
          // Set at threshold, clear only below threshold minus delta
          if (bi.w >= bi.pre) begin
            nxt_st.rbit = 1'b1;
          end else if ({1'b0, bi.w} + {1'b0, bi.dlt} < {1'b0, bi.pre}) begin
            nxt_st.rbit = 1'b0;
          end
        end
        RFE_CNT: begin
          if (bi.b) begin
            nxt_st.acc = '0;
          end else if (bi.a && !st_ff.pa) begin
            nxt_st.acc = bi.down ? st_ff.acc - 16'h0001
                                 : st_ff.acc + 16'h0001;
          end
        end
        RFE_TMR: begin
          if (bi.a && !st_ff.pa) begin
            nxt_st.acc = '0;
            nxt_st.sub = '0;
            nxt_st.run = 1'b1;
            nxt_st.rbit = 1'b0;
          end else if (st_ff.run && ms_tick_in) begin
            if (st_ff.sub == tb - 10'h001) begin
              nxt_st.sub = '0;
              nxt_st.acc = st_ff.acc + 16'h0001;
              if (st_ff.acc + 16'h0001 >= bi.pre) begin
                nxt_st.run = 1'b0;
                nxt_st.rbit = 1'b1;
              end
            end else begin
              nxt_st.sub = st_ff.sub + 10'h001;
            end
          end
        end
        RFE_DLAT: nxt_st.rbit = bi.a;
        RFE_ALAT: nxt_st.acc = bi.w;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bi.rbit = st_ff.rbit;
  assign bi.rword = st_ff.acc;
endmodule // rfe_block
`default_nettype wire

// [hw/rfe_pkg_end.sv]
// Spare package unit; it holds no declarations

// [verif/rfe_engine_monitor.sv]
// Port-level assertions for the reflex and fallback engine
`timescale 1ns/1ps
`default_nettype none
module rfe_engine_monitor
  import rfe_pkg::*;
#(
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  // Supervision
  input wire logic bus_lost_in,
  input wire logic mod_hb_miss_in,
  input wire logic mand_fail_in,
  input wire logic auto_cfg_in,
  // Island outputs
  input wire logic [NCH-1:0][15:0] chan_out,
  input wire logic [NCH-1:0] chan_fb_out,
  input wire logic hb_tx_out
);
  logic halted_ff;
  logic fb_nonzero;
  // Shadow of the run bit, so stop checks need no internal probe
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      halted_ff <= 1'b1;
    end else if (reg_wr_in && reg_addr_in == A_CTRL) begin
      halted_ff <= ~reg_wdata_in[0];
    end
  end
  always_comb begin
    fb_nonzero = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (chan_fb_out[i] && chan_out[i] != 16'h0000) begin
        fb_nonzero = 1'b1;
      end
    end
  end
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  // Six cycles cover the input synchroniser and the output register
  sequence s_bus_down;
    bus_lost_in [*6];
  endsequence
  sequence s_halted;
    halted_ff [*4];
  endsequence
  a_rd_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
    else $error("read data not zero outside a read");
  a_rd_unmapped_zero: assert property (reg_rd_in && reg_addr_in == 8'hF0
    |=> reg_rdata_out == 16'h0000) else $error("unmapped read not zero");
  a_hb_pulse_one: assert property (hb_tx_out |=> !hb_tx_out)
    else $error("heartbeat pulse longer than one cycle");
  a_hb_off_bus: assert property (s_bus_down |-> !hb_tx_out)
    else $error("heartbeat sent while bus lost");
  a_hb_off_miss: assert property (mod_hb_miss_in [*6] |-> !hb_tx_out)
    else $error("heartbeat sent while module heartbeat missing");
  a_hb_off_halt: assert property (s_halted |-> !hb_tx_out)
    else $error("heartbeat sent while stopped");
  a_fb_halt_all: assert property (s_halted |-> &chan_fb_out)
    else $error("channel out of fallback while stopped");
  a_fb_mand_all: assert property (mand_fail_in [*6] |-> &chan_fb_out)
    else $error("channel out of fallback on mandatory failure");
  a_auto_cfg_zero: assert property (auto_cfg_in [*6] |-> !fb_nonzero)
    else $error("auto-configured fallback value not zero");
endmodule // rfe_engine_monitor
bind rfe_engine rfe_engine_monitor #(.NCH(NCH)) u_monitor (.clk_sys_in,
  .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .bus_lost_in, .mod_hb_miss_in, .mand_fail_in, .auto_cfg_in,
  .chan_out, .chan_fb_out, .hb_tx_out);
`default_nettype wire

// [verif/rfe_island_model.sv]
// Behavioural island: input modules and a heartbeat listener
`timescale 1ns/1ps
`default_nettype none
module rfe_island_model #(
  parameter int NDI = 8,
  parameter int NAI = 2
) (
  // Clock
  input wire logic clk_sys_in,
  // Heartbeat from the head module
  input wire logic hb_tx_in,
  // Island module signals
  output logic [NDI-1:0] dig_out,
  output logic [NAI-1:0][15:0] ana_out,
  output logic [NDI-1:0] dig_fail_out,
  output logic [NAI-1:0] ana_fail_out,
  output logic mod_hb_miss_out
);
  int hb_seen;
  initial begin
    dig_out = '0;
    ana_out = '0;
    dig_fail_out = '0;
    ana_fail_out = '0;
    mod_hb_miss_out = 1'b0;
    hb_seen = 0;
  end
  always @(posedge clk_sys_in) begin
    if (hb_tx_in) begin
      hb_seen <= hb_seen + 1;
    end
  end
  // Callers sit just after a clock edge, so levels move off the edge
  task set_dig(input int i, input logic v);
    dig_out[i] <= v;
  endtask
  task set_ana(input int i, input logic [15:0] v);
    ana_out[i] <= v;
  endtask
  task set_fail(input int i, input logic v);
    dig_fail_out[i] <= v;
  endtask
  task set_silent(input logic v);
    mod_hb_miss_out <= v;
  endtask
  task clr_hb();
    hb_seen = 0;
  endtask
endmodule // rfe_island_model
`default_nettype wire

// [verif/rfe_engine_bench.sv]
// Self-checking bench for the reflex and fallback engine
`timescale 1ns/1ps
`default_nettype none
module rfe_engine_bench;
  import rfe_pkg::*;
  localparam int MSC = 10;
  localparam logic [15:0] HBP = 16'h0003;
  // Longer than the 10 ms lockout at MSC cycles per ms
  localparam int LOCK = 120;
  logic clk_sys_in, sys_rst_in, reg_wr_in, reg_rd_in, hb_tx_out;
  logic bus_lost_in, mod_hb_miss_in, mand_fail_in, auto_cfg_in;
  logic [7:0] reg_addr_in, dig_in, dig_fail_in, chan_fb_out;
  logic [15:0] reg_wdata_in, reg_rdata_out;
  logic [1:0][15:0] ana_in;
  logic [1:0] ana_fail_in;
  logic [7:0][15:0] chan_out;
  int n_errors, compares;
  int tu [4] = '{10, 100, 1000, 10000};
  rfe_engine #(.MS_CYCLES(MSC), .HB_PER(HBP)) DUT (.clk_sys_in, .sys_rst_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .dig_in, .ana_in, .dig_fail_in, .ana_fail_in, .bus_lost_in,
    .mod_hb_miss_in, .mand_fail_in, .auto_cfg_in, .chan_out, .chan_fb_out,
    .hb_tx_out);
  rfe_island_model u_isl (.clk_sys_in(clk_sys_in), .hb_tx_in(hb_tx_out),
    .dig_out(dig_in), .ana_out(ana_in), .dig_fail_out(dig_fail_in),
    .ana_fail_out(ana_fail_in), .mod_hb_miss_out(mod_hb_miss_in));
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  task give_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, reg_rdata_out);
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    n_errors++;
    $display("CHECK FAILED run length expected end seen hang");
    give_verdict();
  end
  initial begin
    {n_errors, compares} = '0;
    {sys_rst_in, reg_wr_in, reg_rd_in} = 3'b100;
    {reg_addr_in, reg_wdata_in} = '0;
    {bus_lost_in, mand_fail_in, auto_cfg_in} = 3'b000;
    repeat (6) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    tick(1);
    rd(A_SUP, 16'h0064);
    rd(8'hF0, 16'h0000);
    tick(60);
    chk("fb after reset", 16'h00FF, {8'h00, chan_fb_out});
    chk("ch0 default", 16'h0000, chan_out[0]);
    chk("hb while stopped", 16'h0000, 16'(u_isl.hb_seen));
    wr(8'h52, 16'h0001);
    wr(8'h55, 16'h0001);
    wr(8'h54, 16'h0001);
    wr(A_CTRL, 16'h0001);
    for (int k = 0; k < 80 && u_isl.hb_seen == 0; k++) @(posedge clk_sys_in);
    tick(1);
    chk("hb running", 16'h0001, {15'h0, u_isl.hb_seen != 0});
    if (u_isl.hb_seen == 0) begin
      give_verdict();
    end
    chk("fb running", 16'h0000, {14'h0, chan_fb_out[1:0]});
    chk("ch1 master", 16'h0001, chan_out[1]);
    bus_lost_in <= 1'b1;
    tick(6);
    u_isl.clr_hb();
    wr(8'h54, 16'h0000);
    tick(40);
    chk("ch0 preset", 16'h0001, chan_out[0]);
    chk("ch1 hold", 16'h0001, chan_out[1]);
    chk("hb bus lost", 16'h0000, 16'(u_isl.hb_seen));
    auto_cfg_in <= 1'b1;
    tick(6);
    chk("ch0 auto", 16'h0000, chan_out[0]);
    chk("ch1 auto", 16'h0000, chan_out[1]);
    {auto_cfg_in, bus_lost_in} <= 2'b00;
    tick(6);
    chk("fb cleared", 16'h0000, {14'h0, chan_fb_out[1:0]});
    wr(8'h10, 16'h1008);
    wr(8'h11, 16'h00A0);
    u_isl.set_dig(1, 1'b1);
    tick(LOCK);
    u_isl.set_dig(0, 1'b1);
    tick(6);
    chk("and high", 16'h0001, chan_out[2]);
    wr(8'h58, 16'h0000);
    tick(3);
    chk("master ignored", 16'h0001, chan_out[2]);
    u_isl.set_dig(0, 1'b0);
    tick(30);
    chk("in lockout", 16'h0001, chan_out[2]);
    tick(100);
    chk("after lockout", 16'h0000, chan_out[2]);
    u_isl.set_dig(0, 1'b1);
    tick(LOCK);
    u_isl.set_silent(1'b1);
    tick(6);
    chk("reflex no hb", 16'h0001, {15'h0, chan_out[2][0]});
    chk("fb no hb", 16'h0001, {14'h0, chan_fb_out[2], chan_fb_out[0]});
    u_isl.set_silent(1'b0);
    bus_lost_in <= 1'b1;
    tick(6);
    chk("reflex bus lost", 16'h0001, {15'h0, chan_fb_out[2]});
    bus_lost_in <= 1'b0;
    u_isl.set_fail(1, 1'b1);
    tick(6);
    chk("source failed", 16'h0001, {15'h0, chan_fb_out[2]});
    u_isl.set_fail(1, 1'b0);
    wr(8'h18, 16'h000A);
    wr(8'h19, 16'h0002);
    wr(8'h1A, 16'h0100);
    wr(8'h1B, 16'h0010);
    u_isl.set_ana(1, 16'h0100);
    tick(LOCK);
    rd(8'h3A, 16'h0001);
    u_isl.set_ana(1, 16'h00F8);
    tick(LOCK);
    rd(8'h3A, 16'h0001);
    u_isl.set_ana(1, 16'h00EF);
    tick(LOCK);
    rd(8'h3A, 16'h0000);
    wr(8'h1C, 16'h540B);
    wr(8'h20, 16'h000A);
    wr(8'h21, 16'h0121);
    wr(8'h22, 16'h0002);
    for (int p = 1; p <= 2; p++) begin
      u_isl.set_dig(4, 1'b1);
      tick(LOCK);
      u_isl.set_dig(4, 1'b0);
      tick(LOCK);
      rd(8'h3B, 16'(p));
      chk("nested out", 16'(p - 1), chan_out[4]);
    end
    // Analog latch on analog input 1, mapped to analog channel 6
    wr(8'h24, 16'h000E);
    wr(8'h25, 16'h01A2);
    wr(8'h69, 16'h0002);
    wr(8'h6A, 16'h1234);
    tick(3);
    rd(8'h3D, 16'h00EF);
    chk("latch out", 16'h00EF, chan_out[6]);
    bus_lost_in <= 1'b1;
    tick(6);
    chk("analog preset", 16'h1234, chan_out[6]);
    bus_lost_in <= 1'b0;
    wr(8'h14, 16'h320C);
    wr(8'h16, 16'h0002);
    for (int t = 0; t < 4; t++) begin
      wr(8'h15, 16'(t << 3));
      u_isl.set_dig(3, 1'b1);
      tick(LOCK);
      rd(8'h39, 16'h0000);
      u_isl.set_dig(3, 1'b0);
      tick(LOCK);
      u_isl.set_dig(2, 1'b0);
      tick(LOCK);
      u_isl.set_dig(2, 1'b1);
      tick(tu[t] / 2);
      rd(8'h39, 16'h0000);
      tick(2 * tu[t] + 10);
      rd(8'h39, 16'h0001);
    end
    mand_fail_in <= 1'b1;
    tick(8);
    chk("fb mandatory", 16'h00FF, {8'h00, chan_fb_out});
    give_verdict();
  end
endmodule // rfe_engine_bench
`default_nettype wire
